// ==== sim/mmc_master.sv ====
module mmc_master (
  input logic mclk_in, ack_in, err_in, excl_ok_in,
  input logic [31:0] rdata_in,
  output logic req_out = 1'b0, dma_out = 1'b0, wr_out = 1'b0, excl_out = 1'b0, kh_wr_out = 1'b0,
  output logic [1:0] size_out = 2'h0, kh_reg_out = 2'h0,
  output logic [31:0] addr_out = 32'h0, wdata_out = 32'h0, kh_data_out = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rd;
  logic ak, er, xo;
  // answer is fixed one cycle after the take, so it is read at the falling edge between
  task acc(input logic d, w, x, input logic [1:0] s, input logic [31:0] a, wd);
    @(negedge mclk_in);
    {req_out, dma_out, wr_out, excl_out, size_out, addr_out, wdata_out} = {1'b1, d, w, x, s, a, wd};
    @(negedge mclk_in);
    {rd, ak, er, xo} = {rdata_in, ack_in, err_in, excl_ok_in};
    req_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~wd;
  endtask
  task kh(input logic [1:0] r, input logic [31:0] v);
    @(negedge mclk_in);
    {kh_wr_out, kh_reg_out, kh_data_out} = {1'b1, r, v};
    @(negedge mclk_in);
    kh_wr_out = 1'b0;
    kh_data_out = ~v;
  endtask
endmodule

// ==== sim/mmc_memory_map_bench.sv ====
`include "mmc_map.vh"
module mmc_memory_map_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, rst_n_in = 0, ce_in = 1, isram_en_in = 1, cache_en_in = 0;
  logic parity_en_in = 0, ecc_dis_in = 0;
  logic [1:0] hib_ret_sel_in = 2'h0;
  wire req_in, is_dma_in, wr_in, excl_in, kh_wr_in, ack_out, err_out, excl_ok_out;
  wire parity_err_out, flash_sel_out, prefetch_out, mmr_sel_out, sys_sel_out;
  wire flash_go_out, cmd_refused_out, ecc_en_out;
  wire [1:0] size_in, kh_reg_in;
  wire [3:0] flash_cmd_out, ret_bank_out;
  wire [31:0] addr_in, wdata_in, kh_data_in, rdata_out, prefetch_addr_out, flash_addr_out;
  wire [31:0] flash_data_out, ret_kb_out;
  int failures = 0, tests_run = 0;
  always #5 mclk_in = ~mclk_in;
  mmc_memory_map #(.AW(6)) uut (.*);
  mmc_master m (.mclk_in(mclk_in), .ack_in(ack_out), .err_in(err_out), .excl_ok_in(excl_ok_out),
    .rdata_in(rdata_out), .req_out(req_in), .dma_out(is_dma_in), .wr_out(wr_in),
    .excl_out(excl_in), .kh_wr_out(kh_wr_in), .size_out(size_in), .kh_reg_out(kh_reg_in),
    .addr_out(addr_in), .wdata_out(wdata_in), .kh_data_out(kh_data_in));
  task chk(input logic [31:0] e, s, input string n);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task a(input logic d, w, x, input logic [1:0] s, input logic [31:0] ad, wd, input logic e);
    m.acc(d, w, x, s, ad, wd);
    chk(1, m.ak, "ack");
    chk(e, m.er, "err");
  endtask
  task rd(input logic d, input logic [31:0] ad, ev);
    a(d, 0, 0, 2'h2, ad, 32'h0, 0);
    chk(ev, m.rd, "rdata");
  endtask
  initial begin
    #20000;
    failures++;
    close_out;
  end
  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1;
    chk(1, ecc_en_out, "ecc_en");
    a(0, 1, 0, 2'h2, 32'h20000004, 32'h11223344, 0);
    a(1, 1, 0, 2'h0, 32'h20000005, 32'h0000cc00, 0);
    a(0, 1, 0, 2'h1, 32'h20000006, 32'h77770000, 0);
    rd(1, 32'h20000004, 32'h7777cc44);
    a(1, 0, 0, 2'h2, 32'he0000000, 32'h0, 1);
    a(0, 0, 0, 2'h2, 32'he003fffc, 32'h0, 0);
    chk(1, sys_sel_out, "sys_sel");
    a(0, 0, 0, 2'h2, 32'h40000000, 32'h0, 0);
    chk(1, mmr_sel_out, "mmr_sel");
    a(0, 0, 0, 2'h2, 32'h30000000, 32'h0, 1);
    a(0, 0, 0, 2'h2, 32'h20010000, 32'h0, 1);
    a(0, 0, 0, 2'h2, 32'h0001fbf4, 32'h0, 0);
    chk(32'h0001fc00, prefetch_addr_out, "prefetch");
    a(1, 0, 0, 2'h2, 32'h0003fffc, 32'h0, 0);
    a(0, 0, 0, 2'h2, 32'h20008000, 32'h0, 1);
    cache_en_in = 1;
    a(0, 0, 0, 2'h2, 32'h10007000, 32'h0, 1);
    a(0, 0, 0, 2'h2, 32'h10006ffc, 32'h0, 0);
    a(0, 0, 1, 2'h2, 32'h20000008, 32'h0, 0);
    a(0, 1, 1, 2'h2, 32'h20000008, 32'h1, 0);
    chk(1, m.xo, "excl_ok");
    a(0, 1, 1, 2'h2, 32'h20000008, 32'h2, 0);
    chk(0, m.xo, "excl_ok");
    rd(0, 32'h20000008, 32'h1);
    isram_en_in = 0;
    parity_en_in = 1;
    a(1, 1, 0, 2'h2, 32'h20008000, 32'hdeadbeef, 0);
    rd(0, 32'h20008000, 32'hdeadbeef);
    @(negedge mclk_in);
    chk(0, parity_err_out, "parity_err");
    for (int c = 1; c < 4; c++) begin
      m.kh(2'h3, c);
      chk(c == 1, flash_go_out, "go_nokey");
      m.kh(2'h2, `MMC_USER_KEY);
      m.kh(2'h3, c);
      chk(1, flash_go_out, "go_key");
      chk(c, flash_cmd_out, "cmd");
    end
    m.kh(2'h0, 32'h00001000);
    m.kh(2'h1, 32'hcafef00d);
    chk(32'h00001000, flash_addr_out, "flash_addr");
    chk(32'hcafef00d, flash_data_out, "flash_data");
    m.kh(2'h2, `MMC_USER_KEY);
    m.kh(2'h2, 32'h00000000);
    m.kh(2'h3, 32'h00000002);
    chk(1, cmd_refused_out, "refused");
    chk(0, flash_go_out, "go_badkey");
    ecc_dis_in = 1;
    @(negedge mclk_in);
    chk(0, ecc_en_out, "ecc_off");
    ecc_dis_in = 0;
    for (int i = 0; i < 4; i++) begin
      hib_ret_sel_in = i[1:0];
      repeat (3) @(negedge mclk_in);
      chk(32'h8 + (i[0] ? 32'h10 : 32'h0) + (i[1] ? 32'h8 : 32'h0), ret_kb_out, "ret_kb");
      chk({i[0], i[0], i[1], 1'b1}, ret_bank_out, "ret_bank");
    end
    ce_in = 0;
    hib_ret_sel_in = 2'h0;
    repeat (3) @(negedge mclk_in);
    chk(32'h20, ret_kb_out, "ret_frozen");
    ce_in = 1;
    close_out;
  end
endmodule

// ==== sim/mmc_memory_map_chk.sv ====
`include "mmc_map.vh"
module mmc_memory_map_chk (
  input logic mclk_in, rst_n_in, ce_in, req_in, is_dma_in, wr_in, kh_wr_in,
  input logic [1:0] kh_reg_in,
  input logic [31:0] addr_in, kh_data_in, prefetch_addr_out,
  input logic ack_out, err_out, flash_sel_out, prefetch_out, sys_sel_out,
  input logic flash_go_out, cmd_refused_out,
  input logic [3:0] flash_cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic key_ff;
  wire take = ce_in && req_in;
  wire priv = addr_in >= `MMC_SYS_BASE && addr_in < `MMC_PRIV_END;
  wire cmd_wr = ce_in && kh_wr_in && kh_reg_in == 2'h3;
  wire erase = kh_data_in[3:0] == `MMC_CMD_PAGE_ERASE || kh_data_in[3:0] == `MMC_CMD_MASS_ERASE;
  // every key write reloads the flag, right or wrong; every command write consumes it
  always @(posedge mclk_in)
    if (!rst_n_in) key_ff <= 1'b0;
    else if (ce_in && kh_wr_in && kh_reg_in == 2'h2) key_ff <= kh_data_in == `MMC_USER_KEY;
    else if (cmd_wr) key_ff <= 1'b0;
  sequence keyed_erase_s;
    cmd_wr && erase && key_ff;
  endsequence
  sequence go_s;
    flash_go_out && !cmd_refused_out && flash_cmd_out == $past(kh_data_in[3:0]);
  endsequence
  answer_ack_a: assert property (take |=> ack_out) else $error("request not answered");
  ack_cause_a: assert property (ack_out |-> $past(take)) else $error("ack without request");
  dma_private_a: assert property (take && is_dma_in && priv |=> err_out)
    else $error("dma reached private space");
  core_private_a: assert property (take && !is_dma_in && priv |=> !err_out && sys_sel_out)
    else $error("core refused in private space");
  unmapped_err_a: assert property (take && addr_in[31:28] == 4'h3 |=> ack_out && err_out)
    else $error("unmapped access without error");
  code_fetch_a: assert property (take && !is_dma_in && !wr_in && addr_in < `MMC_CODE_END_SMALL
    |=> flash_sel_out && prefetch_out && prefetch_addr_out == ($past(addr_in) & 32'hfffffff0) + 32'h10)
    else $error("code read not sent to flash with prefetch");
  keyed_go_a: assert property (keyed_erase_s |=> go_s) else $error("keyed erase not issued");
  unkeyed_refuse_a: assert property (cmd_wr && erase && !key_ff |=> cmd_refused_out && !flash_go_out)
    else $error("erase issued without key");
endmodule
bind mmc_memory_map mmc_memory_map_chk chk (.*);

// ==== src/mmc_map.vh ====
`ifndef MMC_MAP_VH
`define MMC_MAP_VH
// region bounds
`define MMC_CODE_END_SMALL 32'h0001fc00
`define MMC_CODE_END_LARGE 32'h0003ffff
`define MMC_SRAM_BASE 32'h20000000
`define MMC_SRAM_END 32'h20047fff
`define MMC_DSRAM0_END 32'h20007fff
`define MMC_DSRAM1_BASE 32'h20008000
`define MMC_DSRAM1_END 32'h2000ffff
`define MMC_MMR_BASE 32'h40000000
`define MMC_MMR_END 32'h4fffffff
`define MMC_SYS_BASE 32'he0000000
`define MMC_PRIV_END 32'he0040000
`define MMC_SYS_END 32'hf7ffffff
// instruction bank: 32 KB, cache takes the top 4 KB
`define MMC_ISRAM_BASE 32'h10000000
`define MMC_ISRAM_END 32'h10007fff
`define MMC_ISRAM_CACHE_BASE 32'h10007000
// key-hole command codes
`define MMC_CMD_NONE 4'h0
`define MMC_CMD_WRITE 4'h1
`define MMC_CMD_PAGE_ERASE 4'h2
`define MMC_CMD_MASS_ERASE 4'h3
`define MMC_USER_KEY 32'h676c7565
// retention field positions
`define MMC_RET_ISRAM_BIT 0
`define MMC_RET_DSRAM_BIT 1
// reset values
`define MMC_ECC_EN_RST 1'b1
`endif

// ==== src/mmc_memory_map.v ====
`include "mmc_map.vh"
// What this block does
// (RULE1) code region from zero to variant end goes to flash and cache
// (RULE2) 0x20000000..0x20047fff goes to internal sram and system registers; only the data sram part is mapped, the rest ends in a bus error
// (RULE3) data sram answers each access in one cycle, no wait states
// (RULE4) system region stays in core; core-private space refuses dma masters
// (RULE5) sram takes byte, half-word and word reads and writes from both masters
// (RULE6) exclusive load/store tracked by a global exclusive monitor
// (RULE7) instruction sram disabled maps its 32 KB as data, 64 KB total
// (RULE8) optional two parity bits per 32-bit word, checked on reads
// (RULE9) cache enable reserves 4 KB of instruction sram
// (RULE10) hibernate keeps 8 KB data; optionally 16 KB instr and 8 KB more data
// (RULE11) flash prefetch works with cache to cut fetch stalls
// (RULE12) flash programmed only by key-hole writes, dma writes accepted too
// (RULE13) erase commands refused unless the user key was presented
// (RULE14) flash 8-bit ecc enabled out of reset
// (RULE15) unmapped or dma-to-private accesses end with a bus error
module mmc_memory_map #(
  parameter LARGE_CODE = 1,
  parameter AW = 13
) (
  // clock, reset, enable
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // configuration
  input wire isram_en_in,
  input wire cache_en_in,
  input wire parity_en_in,
  input wire ecc_dis_in,
  input wire [1:0] hib_ret_sel_in,
  // bus request
  input wire req_in,
  input wire is_dma_in,
  input wire wr_in,
  input wire excl_in,
  input wire [1:0] size_in,
  input wire [31:0] addr_in,
  input wire [31:0] wdata_in,
  // key-hole port
  input wire kh_wr_in,
  input wire [1:0] kh_reg_in,
  input wire [31:0] kh_data_in,
  // bus answer
  output reg ack_out,
  output reg err_out,
  output reg excl_ok_out,
  output wire [31:0] rdata_out,
  output reg parity_err_out,
  // downstream selects
  output reg flash_sel_out,
  output reg prefetch_out,
  output reg [31:0] prefetch_addr_out,
  output reg mmr_sel_out,
  output reg sys_sel_out,
  // flash key-hole outputs
  output reg [3:0] flash_cmd_out,
  output reg [31:0] flash_addr_out,
  output reg [31:0] flash_data_out,
  output reg flash_go_out,
  output reg cmd_refused_out,
  output reg ecc_en_out,
  // hibernate retention
  output reg [31:0] ret_kb_out,
  output reg [3:0] ret_bank_out
);
  localparam [31:0] CODE_END = LARGE_CODE ? `MMC_CODE_END_LARGE : `MMC_CODE_END_SMALL;
  localparam [1:0] KH_ADDR = 2'h0;
  localparam [1:0] KH_DATA = 2'h1;
  localparam [1:0] KH_KEY = 2'h2;
  localparam [1:0] KH_CMD = 2'h3;

  reg in_code;
  reg in_isram;
  reg in_dsram;
  reg in_mmr;
  reg in_sys;
  reg in_priv;
  reg hit_sram;
  reg [3:0] be;
  reg sram_sel;
  reg [AW:0] sram_idx;
  reg key_ok_ff;
  reg nxt_key_ok;
  // exclusive monitor: one address, cleared by any store into the sram
  reg mon_valid_ff;
  reg mon_hit;
  reg bank_sel;
  reg [31:0] nxt_ret_kb;
  reg [3:0] nxt_ret_bank;
  reg [31:0] mon_addr_ff;
  reg rd_sram_ff;
  wire [31:0] bank_rdata;
  wire bank_par_err;

  always @* begin
    in_code = addr_in <= CODE_END; // RULE1
    // instruction bank usable only when enabled; top 4 KB lost to cache
    in_isram = isram_en_in && addr_in >= `MMC_ISRAM_BASE && addr_in <= `MMC_ISRAM_END
      && !(cache_en_in && addr_in >= `MMC_ISRAM_CACHE_BASE); // RULE9
    in_dsram = addr_in >= `MMC_SRAM_BASE && (addr_in <= `MMC_DSRAM0_END
      || (!isram_en_in && addr_in <= `MMC_DSRAM1_END)); // RULE7
    in_mmr = addr_in >= `MMC_MMR_BASE && addr_in <= `MMC_MMR_END;
    hit_sram = addr_in >= `MMC_SRAM_BASE && addr_in <= `MMC_SRAM_END; // RULE2
    in_sys = addr_in >= `MMC_SYS_BASE && addr_in <= `MMC_SYS_END; // RULE4
    in_priv = addr_in >= `MMC_SYS_BASE && addr_in < `MMC_PRIV_END; // RULE4
    case (size_in) // RULE5
      2'h0: be = 4'h1 << addr_in[1:0];
      2'h1: be = addr_in[1] ? 4'hc : 4'h3;
      default: be = 4'hf;
    endcase
    sram_sel = req_in && (in_dsram || in_isram);
    // a failing exclusive store must never reach the array
    mon_hit = mon_valid_ff && mon_addr_ff == addr_in;
    bank_sel = sram_sel && !(wr_in && excl_in && !mon_hit); // RULE6
    // the instruction bank reuses the upper half of the array, the same words as the second data half
    sram_idx = in_isram ? {1'b1, addr_in[AW+1:2]} : addr_in[AW+2:2];
  end

  mmc_sram_bank #(.AW(AW + 1)) u_bank (
    .mclk_in(mclk_in),
    .ce_in(ce_in),
    .sel_in(bank_sel),
    .wr_in(wr_in),
    .be_in(be),
    .idx_in(sram_idx),
    .wdata_in(wdata_in),
    .par_en_in(parity_en_in),
    .rdata_out(bank_rdata),
    .par_err_out(bank_par_err)
  );
  // read data valid the cycle after the request (RULE3)
  assign rdata_out = rd_sram_ff ? bank_rdata : 32'h00000000; // RULE3

  // the key is single-use: any command write consumes it, refused or not
  always @* begin
    nxt_key_ok = key_ok_ff;
    if (kh_wr_in && kh_reg_in == KH_KEY) nxt_key_ok = kh_data_in == `MMC_USER_KEY; // RULE13
    else if (kh_wr_in && kh_reg_in == KH_CMD) nxt_key_ok = 1'b0;
  end

  // retention: 8 KB of data is always kept, the two selects add to it
  always @* begin
    nxt_ret_bank = {hib_ret_sel_in[`MMC_RET_ISRAM_BIT], hib_ret_sel_in[`MMC_RET_ISRAM_BIT],
      hib_ret_sel_in[`MMC_RET_DSRAM_BIT], 1'b1}; // RULE10
    nxt_ret_kb = 32'd8; // RULE10
    if (hib_ret_sel_in[`MMC_RET_ISRAM_BIT]) nxt_ret_kb = nxt_ret_kb + 32'd16;
    if (hib_ret_sel_in[`MMC_RET_DSRAM_BIT]) nxt_ret_kb = nxt_ret_kb + 32'd8;
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      excl_ok_out <= 1'b0;
      parity_err_out <= 1'b0;
      flash_sel_out <= 1'b0;
      prefetch_out <= 1'b0;
      prefetch_addr_out <= 32'h00000000;
      mmr_sel_out <= 1'b0;
      sys_sel_out <= 1'b0;
      flash_cmd_out <= `MMC_CMD_NONE;
      flash_addr_out <= 32'h00000000;
      flash_data_out <= 32'h00000000;
      flash_go_out <= 1'b0;
      cmd_refused_out <= 1'b0;
      ecc_en_out <= `MMC_ECC_EN_RST; // RULE14
      ret_kb_out <= 32'h00000000;
      ret_bank_out <= 4'h0;
      key_ok_ff <= 1'b0;
      mon_valid_ff <= 1'b0;
      mon_addr_ff <= 32'h00000000;
      rd_sram_ff <= 1'b0;
    end else if (ce_in) begin
      ack_out <= req_in;
      // unmapped or dma into core-private space is an error
      err_out <= req_in && ((is_dma_in && in_priv) ||
        !(in_code || in_isram || in_dsram || in_mmr || in_sys)); // RULE15
      flash_sel_out <= req_in && in_code && !wr_in; // RULE1
      mmr_sel_out <= req_in && in_mmr && hit_sram == 1'b0; // RULE2
      sys_sel_out <= req_in && in_sys && !(is_dma_in && in_priv); // RULE4
      // remembers a bank read so that the answer cycle picks the bank data
      rd_sram_ff <= sram_sel && !wr_in;
      parity_err_out <= rd_sram_ff && bank_par_err; // RULE8
      // next-line prefetch after each code fetch (RULE11)
      prefetch_out <= req_in && in_code && !wr_in && !is_dma_in; // RULE11
      if (req_in && in_code && !wr_in) prefetch_addr_out <= {addr_in[31:4] + 28'h0000001, 4'h0};
      // exclusive monitor (RULE6)
      excl_ok_out <= 1'b0;
      if (sram_sel && excl_in && !wr_in) begin // RULE6
        mon_valid_ff <= 1'b1;
        mon_addr_ff <= addr_in;
      end else if (sram_sel && wr_in) begin
        if (excl_in) excl_ok_out <= mon_hit; // RULE6
        mon_valid_ff <= 1'b0;
      end
      // key-hole, from core or dma alike (RULE12)
      key_ok_ff <= nxt_key_ok;
      flash_go_out <= 1'b0;
      cmd_refused_out <= 1'b0;
      if (kh_wr_in) begin // RULE12
        case (kh_reg_in)
          KH_ADDR: flash_addr_out <= kh_data_in;
          KH_DATA: flash_data_out <= kh_data_in;
          KH_CMD: begin
            if (kh_data_in[3:0] == `MMC_CMD_WRITE || key_ok_ff) begin // RULE13
              flash_cmd_out <= kh_data_in[3:0];
              flash_go_out <= 1'b1;
            end else begin
              cmd_refused_out <= 1'b1; // RULE13
            end
          end
          default: ;
        endcase
      end
      ecc_en_out <= !ecc_dis_in; // RULE14
      ret_bank_out <= nxt_ret_bank; // RULE10
      ret_kb_out <= nxt_ret_kb; // RULE10
    end
  end
endmodule

// ==== src/mmc_sram_bank.v ====
module mmc_sram_bank #(
  parameter AW = 13
) (
  // clock and enable
  input wire mclk_in,
  input wire ce_in,
  // access
  input wire sel_in,
  input wire wr_in,
  input wire [3:0] be_in,
  input wire [AW-1:0] idx_in,
  input wire [31:0] wdata_in,
  input wire par_en_in,
  // answer
  output reg [31:0] rdata_out,
  output reg par_err_out
);
  reg [31:0] mem [0:(1<<AW)-1];
  reg [1:0] par_mem [0:(1<<AW)-1];
  wire [31:0] merged;
  reg [1:0] rd_par;
  genvar g;
  // a sub-word store keeps the lanes it does not enable
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      assign merged[8*g+7:8*g] = be_in[g] ? wdata_in[8*g+7:8*g] : mem[idx_in][8*g+7:8*g]; // RULE5
    end
  endgenerate
  always @* begin
    rd_par = {^mem[idx_in][31:16], ^mem[idx_in][15:0]};
  end
  // one-cycle read, no wait states (RULE3) with byte lanes (RULE5)
  always @(posedge mclk_in) begin
    if (ce_in && sel_in) begin
      if (wr_in) begin
        mem[idx_in] <= merged; // RULE5
        par_mem[idx_in] <= {^merged[31:16], ^merged[15:0]}; // RULE8
      end
      rdata_out <= mem[idx_in]; // RULE3
      par_err_out <= !wr_in && par_en_in && (rd_par != par_mem[idx_in]); // RULE8
    end
  end
endmodule
